// ---- hdl/pulse_timer_pkg.sv ----
// Package holding the register map, field layout, codes and counts of the pulse timer.
package pulse_timer_pkg;

    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_CTRL3 = 8'h08;
    localparam logic [7:0] ADDR_PERIOD = 8'h0C;
    localparam logic [7:0] ADDR_DEAD_ONE = 8'h10;
    localparam logic [7:0] ADDR_DEAD_TWO = 8'h14;
    localparam logic [7:0] ADDR_COUNT = 8'h18;

    localparam int C1_START_LO = 0;
    localparam int C1_EDGE = 2;
    localparam int C1_INI_ONE = 3;
    localparam int C1_INI_TWO = 4;
    localparam int C1_FILT_LO = 5;
    localparam int C2_OE_ONE = 0;
    localparam int C2_OE_TWO = 1;
    localparam int C2_EMG_EN = 2;
    localparam int C2_EMG_REL = 7;
    localparam int C3_RUN = 0;
    localparam int C3_STM_LO = 1;
    localparam int C3_BUSY = 3;
    localparam int C3_EMGF = 4;

    localparam logic [1:0] START_CAPTURE = 2'h0;
    localparam logic [1:0] START_CMD_TRIG = 2'h1;
    localparam logic [1:0] START_TRIG = 2'h2;

    localparam logic [1:0] STM_INIT = 2'h0;
    localparam logic [1:0] STM_HOLD = 2'h1;
    localparam logic [1:0] STM_ONCE = 2'h2;

    localparam logic [1:0] FILT_DIV4 = 2'h0;
    localparam logic [1:0] FILT_DIV2 = 2'h1;
    localparam logic [1:0] FILT_FULL = 2'h2;
    localparam logic [1:0] FILT_NONE = 2'h3;

    localparam logic [6:0] CTRL1_RESET = 7'h00;
    localparam logic [2:0] CTRL2_RESET = 3'h0;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] DEAD_RESET = 16'h0000;

    localparam logic [2:0] FILT_SAMPLES = 3'h5;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [1:0] EMG_SAMPLES = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WAIT = 2'b10
    } count_state_t;

endpackage

// ---- hdl/pulse_timer_output_control.sv ----
// Pulse timer counter, output control, trigger filter and emergency stop with APB registers.
`timescale 1ns/100ps
module pulse_timer_output_control import pulse_timer_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_input_pin,
    input wire logic emergency_stop_pin_n,
    output logic pulse_out_one,
    output logic pulse_out_two,
    output logic out_one_oe,
    output logic out_two_oe,
    output logic trigger_start_irq,
    output logic period_irq,
    output logic emergency_stop_irq
);

    // ======================================================================
    // Register bus
    logic [6:0] ctrl1_reg;
    logic [2:0] ctrl2_reg;
    logic run_reg;
    logic [1:0] stm_reg;
    logic [15:0] period_reg;
    logic [15:0] dead_one_reg;
    logic [15:0] dead_two_reg;
    logic [15:0] cnt_reg;
    logic emg_flag_reg;
    count_state_t state_reg;
    logic pending_reg;
    logic mapped;
    logic wr_access;
    logic wr_ctrl3;
    logic [31:0] rd_next;

    always_comb begin
        case (paddr)
            ADDR_CTRL1, ADDR_CTRL2, ADDR_CTRL3, ADDR_PERIOD,
            ADDR_DEAD_ONE, ADDR_DEAD_TWO, ADDR_COUNT: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_access = psel & penable & pwrite & mapped;
    assign wr_ctrl3 = wr_access & (paddr == ADDR_CTRL3);

    always_comb begin
        rd_next = 32'h00000000;
        case (paddr)
            ADDR_CTRL1: begin
                rd_next[6:0] = ctrl1_reg;
            end
            ADDR_CTRL2: begin
                rd_next[2:0] = ctrl2_reg;
            end
            ADDR_CTRL3: begin
                rd_next[C3_RUN] = run_reg;
                rd_next[C3_STM_LO +: 2] = stm_reg;
                rd_next[C3_BUSY] = (state_reg == ST_RUN);
                rd_next[C3_EMGF] = emg_flag_reg;
            end
            ADDR_PERIOD: begin
                rd_next[15:0] = period_reg;
            end
            ADDR_DEAD_ONE: begin
                rd_next[15:0] = dead_one_reg;
            end
            ADDR_DEAD_TWO: begin
                rd_next[15:0] = dead_two_reg;
            end
            ADDR_COUNT: begin
                rd_next[15:0] = cnt_reg;
            end
            default: begin
                rd_next = 32'h00000000;
            end
        endcase
    end

    // Read data is captured in the setup cycle so it is stable for the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_reg <= CTRL1_RESET;
            ctrl2_reg <= CTRL2_RESET;
            period_reg <= PERIOD_RESET;
            dead_one_reg <= DEAD_RESET;
            dead_two_reg <= DEAD_RESET;
        end else if (wr_access) begin
            case (paddr)
                ADDR_CTRL1: begin
                    ctrl1_reg <= pwdata[6:0];
                end
                ADDR_CTRL2: begin
                    ctrl2_reg <= pwdata[2:0];
                end
                ADDR_PERIOD: begin
                    period_reg <= pwdata[15:0];
                end
                ADDR_DEAD_ONE: begin
                    dead_one_reg <= pwdata[15:0];
                end
                ADDR_DEAD_TWO: begin
                    dead_two_reg <= pwdata[15:0];
                end
                default: begin
                    ctrl1_reg <= ctrl1_reg;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
            stm_reg <= STM_INIT;
        end else if (wr_ctrl3) begin
            run_reg <= pwdata[C3_RUN];
            stm_reg <= pwdata[C3_STM_LO +: 2];
        end
    end

    logic [1:0] start_mode;
    logic edge_sel;
    logic ini_one;
    logic ini_two;
    logic [1:0] filt_sel;
    assign start_mode = ctrl1_reg[C1_START_LO +: 2];
    assign edge_sel = ctrl1_reg[C1_EDGE];
    assign ini_one = ctrl1_reg[C1_INI_ONE];
    assign ini_two = ctrl1_reg[C1_INI_TWO];
    assign filt_sel = ctrl1_reg[C1_FILT_LO +: 2];

    // ======================================================================
    // Trigger noise filter
    logic trig_ff_reg;
    logic [1:0] div_reg;
    logic sample_en;
    logic [2:0] agree_reg;
    logic filt_reg;
    logic trig_level;
    logic trig_prev_reg;
    logic filt_accept;
    logic filt_next;
    logic lag_in;
    logic [2:0] lag_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_ff_reg <= 1'b0;
            div_reg <= 2'h0;
        end else begin
            trig_ff_reg <= trigger_input_pin;
            div_reg <= div_reg + 2'h1;
        end
    end

    always_comb begin
        case (filt_sel)
            FILT_DIV4: begin
                sample_en = (div_reg == DIV4_LAST);
            end
            FILT_DIV2: begin
                sample_en = div_reg[0];
            end
            default: begin
                sample_en = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agree_reg <= 3'h0;
            filt_reg <= 1'b0;
        end else if (sample_en) begin
            if (trig_ff_reg == filt_reg) begin
                agree_reg <= 3'h0;
            end else if (agree_reg == FILT_SAMPLES - 3'h1) begin
                agree_reg <= 3'h0;
                filt_reg <= trig_ff_reg;
            end else begin
                agree_reg <= agree_reg + 3'h1;
            end
        end
    end

    assign filt_accept = sample_en & (trig_ff_reg != filt_reg)
        & (agree_reg == FILT_SAMPLES - 3'h1);
    assign filt_next = filt_accept ? trig_ff_reg : filt_reg;
    assign lag_in = (filt_sel == FILT_NONE) ? trig_ff_reg : filt_reg;

    // A three-stage lag sets the trigger latency of the bypass and slow filter codes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lag_reg <= 3'h0;
        end else begin
            lag_reg <= {lag_reg[1:0], lag_in};
        end
    end

    assign trig_level = (filt_sel == FILT_FULL) ? filt_next : lag_reg[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_level;
        end
    end

    logic trig_on;
    logic at_stop_level;
    logic start_edge;
    assign trig_on = run_reg & (start_mode != START_CAPTURE);
    assign at_stop_level = (trig_level != edge_sel);
    assign start_edge = trig_on & (trig_level == edge_sel) & (trig_prev_reg != edge_sel);

    // ======================================================================
    // Emergency stop
    logic [1:0] emg_cnt_reg;
    logic emg_detect;
    logic emg_release;
    assign emg_detect = ctrl2_reg[C2_EMG_EN] & (emg_cnt_reg == EMG_SAMPLES);
    assign emg_release = wr_access & (paddr == ADDR_CTRL2) & pwdata[C2_EMG_REL]
        & ~run_reg & (stm_reg == STM_INIT);

    // Low level is accepted after a short run of low samples.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emg_cnt_reg <= 2'h0;
        end else if (emergency_stop_pin_n) begin
            emg_cnt_reg <= 2'h0;
        end else if (emg_cnt_reg != EMG_SAMPLES) begin
            emg_cnt_reg <= emg_cnt_reg + 2'h1;
        end
    end

    // A detected low level at release sets the flag again, set winning over clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emg_flag_reg <= 1'b0;
            emergency_stop_irq <= 1'b0;
        end else begin
            emergency_stop_irq <= emg_detect & (~emg_flag_reg | emg_release);
            if (emg_detect) begin
                emg_flag_reg <= 1'b1;
            end else if (emg_release) begin
                emg_flag_reg <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Counter sequencing
    logic cmd_start;
    logic cmd_stop;
    logic once_restart;
    logic period_end;
    logic [1:0] stm_new;
    assign stm_new = pwdata[C3_STM_LO +: 2];
    assign once_restart = run_reg & (stm_new == STM_ONCE) & (stm_reg != STM_ONCE);
    assign cmd_start = wr_ctrl3 & pwdata[C3_RUN] & (start_mode != START_TRIG)
        & (~run_reg | (state_reg == ST_WAIT) | once_restart);
    assign cmd_stop = wr_ctrl3 & ~pwdata[C3_RUN] & run_reg;
    assign period_end = (state_reg == ST_RUN) & (cnt_reg == period_reg);

    logic lvl_one_reg;
    logic lvl_two_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            pending_reg <= 1'b0;
            lvl_one_reg <= 1'b0;
            lvl_two_reg <= 1'b0;
            period_irq <= 1'b0;
            trigger_start_irq <= 1'b0;
        end else begin
            period_irq <= 1'b0;
            trigger_start_irq <= 1'b0;
            if (cmd_start) begin
                cnt_reg <= 16'h0000;
                pending_reg <= 1'b0;
                lvl_one_reg <= ini_one;
                lvl_two_reg <= ini_two;
                if (start_mode == START_CMD_TRIG && at_stop_level) begin
                    state_reg <= ST_WAIT;
                end else begin
                    state_reg <= ST_RUN;
                    period_irq <= 1'b1;
                end
            end else if (cmd_stop) begin
                if (stm_reg == STM_ONCE && state_reg == ST_RUN) begin
                    pending_reg <= 1'b1;
                end else begin
                    state_reg <= ST_IDLE;
                    cnt_reg <= 16'h0000;
                    if (stm_reg != STM_HOLD) begin
                        lvl_one_reg <= ini_one;
                        lvl_two_reg <= ini_two;
                    end
                end
            end else if (trig_on && at_stop_level && state_reg != ST_IDLE) begin
                state_reg <= ST_WAIT;
                cnt_reg <= 16'h0000;
                pending_reg <= 1'b0;
                lvl_one_reg <= ini_one;
                lvl_two_reg <= ini_two;
            end else if (start_edge && state_reg != ST_RUN) begin
                state_reg <= ST_RUN;
                cnt_reg <= 16'h0000;
                lvl_one_reg <= ini_one;
                lvl_two_reg <= ini_two;
                trigger_start_irq <= 1'b1;
            end else if (period_end) begin
                cnt_reg <= 16'h0000;
                period_irq <= 1'b1;
                lvl_one_reg <= ini_one;
                lvl_two_reg <= ini_two;
                if (pending_reg) begin
                    state_reg <= ST_IDLE;
                    pending_reg <= 1'b0;
                end else if (stm_reg == STM_ONCE) begin
                    state_reg <= ST_WAIT;
                end
            end else if (state_reg == ST_RUN) begin
                cnt_reg <= cnt_reg + 16'h0001;
                if (cnt_reg == dead_one_reg) begin
                    lvl_one_reg <= ~ini_one;
                end
                if (cnt_reg == dead_two_reg) begin
                    lvl_two_reg <= ~ini_two;
                end
            end
        end
    end

    // ======================================================================
    // Pulse outputs
    assign out_one_oe = ctrl2_reg[C2_OE_ONE];
    assign out_two_oe = ctrl2_reg[C2_OE_TWO];
    assign pulse_out_one = out_one_oe & (emg_flag_reg ? ini_one : lvl_one_reg);
    assign pulse_out_two = out_two_oe & (emg_flag_reg ? ini_two : lvl_two_reg);

endmodule

// ---- bench/pulse_timer_output_control_monitor.sv ----
// Checker of the pulse timer port behaviour.
`timescale 1ns/100ps
module pulse_timer_output_control_monitor import pulse_timer_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trigger_input_pin,
    input wire logic emergency_stop_pin_n,
    input wire logic pulse_out_one,
    input wire logic pulse_out_two,
    input wire logic out_one_oe,
    input wire logic out_two_oe,
    input wire logic trigger_start_irq,
    input wire logic period_irq,
    input wire logic emergency_stop_irq
);
    // ==========================================
    // Shadow of the control bits written by software.
    logic wr;
    logic [1:0] mode_reg;
    logic ini1_reg, ini2_reg, oe1_reg, oe2_reg, run_reg;
    assign wr = psel && penable && pwrite && pready && !pslverr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_reg, ini1_reg, ini2_reg, oe1_reg, oe2_reg, run_reg} <= 7'h00;
        end else if (wr) begin
            if (paddr == ADDR_CTRL1) begin
                {ini2_reg, ini1_reg, mode_reg} <=
                    {pwdata[C1_INI_TWO], pwdata[C1_INI_ONE], pwdata[1:0]};
            end
            if (paddr == ADDR_CTRL2) begin
                {oe2_reg, oe1_reg} <= {pwdata[C2_OE_TWO], pwdata[C2_OE_ONE]};
            end
            if (paddr == ADDR_CTRL3) begin
                run_reg <= pwdata[C3_RUN];
            end
        end
    end
    // ==========================================
    // Assertions.
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_oe_gate_one: assert property (!out_one_oe |-> !pulse_out_one)
        else $error("output one active while disabled");
    a_oe_gate_two: assert property (!out_two_oe |-> !pulse_out_two)
        else $error("output two active while disabled");
    a_oe_follows_ctrl: assert property ({out_two_oe, out_one_oe} == {oe2_reg, oe1_reg})
        else $error("output enables differ from control");
    a_emg_forces_ini: assert property (emergency_stop_irq |=>
        pulse_out_one == (ini1_reg & oe1_reg) && pulse_out_two == (ini2_reg & oe2_reg))
        else $error("emergency did not force initial levels");
    a_emg_needs_low: assert property (emergency_stop_irq |->
        !$past(emergency_stop_pin_n) && !$past(emergency_stop_pin_n, 2))
        else $error("emergency interrupt without low input");
    a_emg_single: assert property (emergency_stop_irq |=> !emergency_stop_irq)
        else $error("emergency interrupt longer than one cycle");
    a_trig_irq_mode: assert property (trigger_start_irq |->
        mode_reg != START_CAPTURE && run_reg)
        else $error("trigger interrupt in capture mode or stopped");
    a_stop_init: assert property (wr && paddr == ADDR_CTRL3 && !pwdata[C3_RUN]
        && pwdata[2:1] == STM_INIT && run_reg |=>
        {pulse_out_two, pulse_out_one} == {ini2_reg & oe2_reg, ini1_reg & oe1_reg})
        else $error("immediate stop did not restore initial levels");
endmodule
bind pulse_timer_output_control pulse_timer_output_control_monitor
    pulse_timer_output_control_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_input_pin, .emergency_stop_pin_n,
    .pulse_out_one, .pulse_out_two, .out_one_oe, .out_two_oe, .trigger_start_irq,
    .period_irq, .emergency_stop_irq);

// ---- bench/trigger_emg_source.sv ----
// Model of the trigger and emergency stop signal sources.
`timescale 1ns/100ps
module trigger_emg_source (
    input wire logic pclk,
    output logic trigger_input_pin,
    output logic emergency_stop_pin_n
);
    initial begin
        trigger_input_pin = 1'b0;
        emergency_stop_pin_n = 1'b1;
    end
    task automatic set_trig(input logic lvl);
        @(posedge pclk);
        trigger_input_pin <= lvl;
    endtask
    task automatic pulse_trig(input logic lvl, input int n);
        set_trig(lvl);
        repeat (n) @(posedge pclk);
        trigger_input_pin <= !lvl;
    endtask
    // The emergency line is never held low for less than four clocks.
    task automatic emg_low(input int n);
        @(posedge pclk);
        emergency_stop_pin_n <= 1'b0;
        repeat ((n < 4) ? 4 : n) @(posedge pclk);
        emergency_stop_pin_n <= 1'b1;
    endtask
endmodule

// ---- bench/pulse_timer_output_control_tb.sv ----
// Self-checking testbench of the pulse timer output control.
`timescale 1ns/100ps
module pulse_timer_output_control_tb import pulse_timer_pkg::*;;
    logic pclk = 1'b0, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, trigger_input_pin, emergency_stop_pin_n, pulse_out_one;
    logic pulse_out_two, out_one_oe, out_two_oe, trigger_start_irq, period_irq;
    logic emergency_stop_irq;
    int n_mismatch = 0, cmp_count = 0, np, nt, ne;
    always #10 pclk = ~pclk;
    pulse_timer_output_control pulse_timer_output_control_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_input_pin,
        .emergency_stop_pin_n, .pulse_out_one, .pulse_out_two, .out_one_oe, .out_two_oe,
        .trigger_start_irq, .period_irq, .emergency_stop_irq);
    trigger_emg_source trigger_emg_source_inst (.pclk, .trigger_input_pin,
        .emergency_stop_pin_n);
    // ==========================================
    // Bus, timing and compare helpers.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        chk(n < 16, 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(a, 1'b1, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        xfer(a, 1'b0, 32'h0, q, e);
        chk(q, exp);
    endtask
    task automatic run_for(input int n);
        np = 0;
        nt = 0;
        ne = 0;
        repeat (n) begin
            @(posedge pclk);
            #1;
            np += int'(period_irq === 1'b1);
            nt += int'(trigger_start_irq === 1'b1);
            ne += int'(emergency_stop_irq === 1'b1);
        end
    endtask
    task automatic gap(output int g);
        g = 0;
        while (period_irq !== 1'b1 && g < 200) begin
            @(posedge pclk);
            #1;
            g++;
        end
        g = 0;
        do begin
            @(posedge pclk);
            #1;
            g++;
        end while (period_irq !== 1'b1 && g < 200);
    endtask
    task automatic lat(output int l);
        l = 0;
        do begin
            @(posedge pclk);
            #1;
            l++;
        end while (trigger_start_irq !== 1'b1 && l < 100);
    endtask
    // ==========================================
    // Scenarios.
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd(ADDR_CTRL1, 32'h0);
        rd(ADDR_CTRL2, 32'h0);
        rd(ADDR_CTRL3, 32'h0);
        rd(ADDR_PERIOD, 32'hFFFF);
        xfer(8'h1C, 1'b0, 32'h0, q, e);
        chk(e, 1'b1);
        chk(q, 32'h0);
    endtask
    task automatic t_cont();
        int g;
        wr(ADDR_PERIOD, 32'h5);
        fork
            wr(ADDR_CTRL3, 32'h1);
            run_for(6);
        join
        chk(np, 32'h1);
        gap(g);
        chk(g, 32'h6);
        gap(g);
        chk(g, 32'h6);
        chk({pulse_out_two, pulse_out_one}, 32'h0);
        wr(ADDR_CTRL3, 32'h0);
    endtask
    task automatic t_polar();
        int g;
        wr(ADDR_CTRL1, 32'h10);
        wr(ADDR_DEAD_ONE, 32'h3);
        wr(ADDR_DEAD_TWO, 32'h3);
        wr(ADDR_PERIOD, 32'h1E);
        wr(ADDR_CTRL2, 32'h3);
        wr(ADDR_CTRL3, 32'h1);
        gap(g);
        run_for(1);
        chk({pulse_out_two, pulse_out_one}, 32'h2);
        run_for(4);
        chk({pulse_out_two, pulse_out_one}, 32'h1);
        wr(ADDR_CTRL3, 32'h0);
        run_for(1);
        chk({pulse_out_two, pulse_out_one}, 32'h2);
        wr(ADDR_CTRL3, 32'h3);
        run_for(6);
        chk({pulse_out_two, pulse_out_one}, 32'h1);
        wr(ADDR_CTRL3, 32'h2);
        run_for(1);
        chk({pulse_out_two, pulse_out_one}, 32'h1);
    endtask
    task automatic t_once();
        logic [31:0] q;
        logic e;
        wr(ADDR_PERIOD, 32'h14);
        wr(ADDR_CTRL3, 32'h5);
        rd(ADDR_CTRL3, 32'hD);
        run_for(60);
        chk(np, 32'h1);
        rd(ADDR_CTRL3, 32'h5);
        fork
            wr(ADDR_CTRL3, 32'h5);
            run_for(60);
        join
        chk(np, 32'h2);
        wr(ADDR_CTRL3, 32'h1);
        run_for(10);
        wr(ADDR_CTRL3, 32'h5);
        xfer(ADDR_COUNT, 1'b0, 32'h0, q, e);
        chk(q < 32'h4, 1'b1);
        wr(ADDR_CTRL3, 32'h4);
        rd(ADDR_CTRL3, 32'hC);
        run_for(40);
        chk(np, 32'h1);
        rd(ADDR_CTRL3, 32'h4);
        wr(ADDR_CTRL3, 32'h0);
    endtask
    task automatic t_trig();
        int l[4];
        trigger_emg_source_inst.set_trig(1'b0);
        wr(ADDR_CTRL1, 32'h66);
        wr(ADDR_CTRL3, 32'h5);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CTRL1, 32'h6 | (c << 5));
            run_for(40);
            trigger_emg_source_inst.set_trig(1'b1);
            lat(l[c]);
            trigger_emg_source_inst.set_trig(1'b0);
            run_for(60);
        end
        chk(l[3] < 8, 1'b1);
        chk(l[2] - l[3], 32'h1);
        chk(l[1] - l[3] inside {[9:10]}, 1'b1);
        chk(l[0] - l[3] inside {[17:20]}, 1'b1);
        wr(ADDR_CTRL1, 32'h46);
        run_for(20);
        fork
            trigger_emg_source_inst.pulse_trig(1'b1, 4);
            run_for(30);
        join
        chk(nt, 32'h0);
        fork
            trigger_emg_source_inst.pulse_trig(1'b1, 5);
            run_for(30);
        join
        chk(nt, 32'h1);
        trigger_emg_source_inst.set_trig(1'b1);
        run_for(80);
        chk({nt[3:0], np[3:0]}, 32'h11);
        rd(ADDR_CTRL3, 32'h5);
        trigger_emg_source_inst.set_trig(1'b0);
        wr(ADDR_CTRL3, 32'h0);
    endtask
    task automatic t_cmd_trig();
        trigger_emg_source_inst.set_trig(1'b1);
        wr(ADDR_CTRL1, 32'h61);
        fork
            wr(ADDR_CTRL3, 32'h1);
            run_for(20);
        join
        chk(np, 32'h0);
        fork
            trigger_emg_source_inst.set_trig(1'b0);
            run_for(10);
        join
        chk(nt, 32'h1);
        wr(ADDR_CTRL3, 32'h0);
    endtask
    task automatic t_emg();
        wr(ADDR_CTRL1, 32'h8);
        wr(ADDR_PERIOD, 32'h5);
        wr(ADDR_CTRL2, 32'h7);
        wr(ADDR_CTRL3, 32'h1);
        fork
            trigger_emg_source_inst.emg_low(4);
            run_for(15);
        join
        chk(ne, 32'h1);
        chk({pulse_out_two, pulse_out_one}, 32'h1);
        run_for(20);
        chk(np > 2, 1'b1);
        chk({pulse_out_two, pulse_out_one}, 32'h1);
        rd(ADDR_CTRL3, 32'h19);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cont();
        t_polar();
        t_once();
        t_trig();
        t_cmd_trig();
        t_emg();
        report_and_stop();
    end
endmodule
